// [logic/uxc_map.vh]
// Register indices, field positions and reset values of the extended control block
`ifndef UXC_MAP_VH
`define UXC_MAP_VH
// Register indices within a bank (byte address is four times the index)
`define UXC_IDX_BASE0 3'h0
`define UXC_IDX_BASE1 3'h1
`define UXC_IDX_BASE2 3'h2
`define UXC_IDX_LCR_BSR 3'h3
`define UXC_IDX_BASE4 3'h4
`define UXC_IDX_RSVD5 3'h5
`define UXC_IDX_TRANSMIT_FIFO_LEVEL 3'h6
`define UXC_IDX_RECEIVE_FIFO_LEVEL 3'h7
// Banks decoded by this block
`define UXC_BANK0 3'h0
`define UXC_BANK1 3'h1
`define UXC_BANK2 3'h2
`define UXC_BANK3 3'h3
// Offset 03h write: bit 7 set selects bank, else line control
`define UXC_BSR_FLAG 7
// extended_control_one fields
`define UXC_X1_EXT 0
`define UXC_X1_SWAP 3
`define UXC_X1_LOOP 4
`define UXC_X1_ETD 5
`define UXC_X1_BAUD_CLOCK_TEST_ROUTE 7
`define UXC_X1_KEEP 8'h0E
`define UXC_X1_FALLBACK_CLR 8'hA1
`define UXC_X1_WMASK 8'hBF
// fifo_and_prescaler_control fields
`define UXC_X2_LOCK 7
`define UXC_X2_FALLBACK_CLR 8'h3F
`define UXC_X2_WMASK 8'hBF
`define UXC_X2_TXSZ_HI 1
`define UXC_X2_TXSZ_LO 0
`define UXC_X2_RXSZ_HI 3
`define UXC_X2_RXSZ_LO 2
`define UXC_X2_PRE_HI 5
`define UXC_X2_PRE_LO 4
`define UXC_FIFO_32 2'h1
// modem_control_register fields
`define UXC_MCR_DTR 0
`define UXC_MCR_RTS 1
`define UXC_MCR_OUT1 2
`define UXC_MCR_OUT2 3
`define UXC_MCR_LOOP 4
`define UXC_MCR_FALLBACK_CLR 8'hFC
// Interrupt enable: modem status enable bit
`define UXC_IER_MS 3
// FIFO control: FIFO enable bit
`define UXC_FCR_EN 0
// Level registers keep bits 5-0
`define UXC_LEVEL_MASK 8'h3F
// Revision identification (values arbitrary)
`define UXC_MODULE_TYPE 4'hA
`define UXC_REVISION 4'h1
// Reset values
`define UXC_RST_BYTE 8'h00
`define UXC_RST_BANK 3'h0
`endif

// [logic/uxc_ext_ctrl.v]
// Extended control and status block of a banked serial port, with Avalon-MM register access
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "uxc_map.vh"

// Summary of operation
// - Swap bit 3 exchanges transmit and receive DMA request/acknowledge pairs.
// - Loop bit 4 wires transmitter to receiver; modem control bit 4 reads it, and writes it in legacy mode only.
// - Extended loopback: DTR drives DSR and RI, RTS drives CTS and DCD.
// - Loopback modem interrupts come from modem control bits, gated by interrupt enable.
// - Infrared mode suppresses modem interrupts unless infrared status select is 0.
// - DMA handling keeps working unchanged during loopback.
// - Loopback ignores external serial inputs; receivers take transmitter outputs.
// - Loopback holds serial out high, infrared out low, unless transmit-during-loopback set.
// - Loopback ignores modem input pins; status comes from modem control bits.
// - Bit 7 routes the baud generator clock onto the DTR pin.
// - FIFO depth fields: 00 gives 16, 01 gives 32, only while FIFOs enabled.
// - Bits 5,4 select prescaler 13, 1.625 or 1.0; code 10 reserved.
// - Divisor lock in legacy mode (bit 0 clear) blocks legacy divisor ports and fallback; scratchpads answer instead.
// - Level registers are read-only, bits 5-0 count, bits 7,6 zero.
// - Revision register is read-only: module type high nibble, revision low nibble.
// - Line control shadow returns line control value with no read side effect.
// - FIFO control shadow returns write-only FIFO control register contents.
// - Offset 03h in banks 2 and 3 is the shared line control/bank select.
// - Bank 2 offset 05h reads zero and ignores writes.
// - Extended mode select bit 0: 1 extended, 0 legacy compatible mode.
module uxc_ext_ctrl (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  // Avalon-MM slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Core side serial and modem
  input wire core_txd,
  input wire core_ir_txd,
  output reg core_rxd,
  output reg core_ir_rxd,
  output reg [3:0] core_modem_status,
  output reg modem_status_irq,
  // Serial pins
  input wire uart_rxd_pin,
  input wire ir_rxd_pin,
  output reg uart_txd_pin,
  output reg ir_txd_pin,
  // Modem pins, active low
  input wire dsr_n_pin,
  input wire cts_n_pin,
  input wire ri_n_pin,
  input wire dcd_n_pin,
  output reg dtr_n_pin,
  output reg rts_n_pin,
  // DMA, core side and channel side
  input wire core_tx_drq,
  input wire core_rx_drq,
  output reg core_tx_dack,
  output reg core_rx_dack,
  output reg chan_a_drq,
  output reg chan_b_drq,
  input wire chan_a_dack,
  input wire chan_b_dack,
  // Baud generator and FIFO interface
  input wire baud_clk,
  input wire [5:0] transmit_byte_count,
  input wire [5:0] receive_byte_count,
  output reg [1:0] prescaler_select,
  output reg transmit_fifo_32,
  output reg receive_fifo_32,
  output reg extended_mode,
  output reg loopback_active,
  // Infrared mode status from infrared banks
  input wire ir_mode_active,
  input wire infrared_modem_status_select
);

  reg ack;
  reg [7:0] extended_control_one;
  reg [7:0] fifo_and_prescaler_control;
  reg [7:0] line_control_register;
  reg [2:0] bank_select_register;
  reg [7:0] modem_control_register;
  reg [7:0] fifo_control_register;
  reg [7:0] interrupt_enable_register;
  reg [7:0] scratch_low;
  reg [7:0] scratch_high;
  reg [3:0] ms_meta;
  reg [3:0] ms_sync;
  reg [1:0] rx_meta;
  reg [1:0] rx_sync;
  reg baud_meta;
  reg baud_sync;
  reg [3:0] ms_prev;
  reg ms_primed;
  reg [3:0] next_status;
  reg [7:0] next_readdata;
  wire [2:0] idx;
  wire wr_go;
  wire rd_go;
  wire loop;
  wire ext;
  wire lock;
  wire legacy_port;

  assign idx = avs_address[4:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~(ack & clk_en);
  assign wr_go = clk_en & avs_write & ack & avs_byteenable[0];
  assign rd_go = clk_en & avs_read & ~ack;
  assign loop = extended_control_one[`UXC_X1_LOOP];
  assign ext = extended_control_one[`UXC_X1_EXT];
  assign lock = fifo_and_prescaler_control[`UXC_X2_LOCK];
  // Bank 1 offsets 0 and 1 are the legacy divisor ports
  assign legacy_port = (bank_select_register == `UXC_BANK1) &&
                       ((idx == `UXC_IDX_BASE0) || (idx == `UXC_IDX_BASE1));

  // Bus handshake: one wait cycle, answer on the second
  always @(posedge sys_clk) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else if (clk_en) begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Register writes and legacy fallback
  always @(posedge sys_clk) begin
    if (!rstn) begin
      extended_control_one <= `UXC_RST_BYTE;
      fifo_and_prescaler_control <= `UXC_RST_BYTE;
      line_control_register <= `UXC_RST_BYTE;
      bank_select_register <= `UXC_RST_BANK;
      modem_control_register <= `UXC_RST_BYTE;
      fifo_control_register <= `UXC_RST_BYTE;
      interrupt_enable_register <= `UXC_RST_BYTE;
      scratch_low <= `UXC_RST_BYTE;
      scratch_high <= `UXC_RST_BYTE;
    end else if (clk_en && ack && (avs_read || avs_write)) begin
      if (legacy_port && !ext && lock) begin
        // Locked: scratchpads overlay the divisor ports
        if (wr_go && idx == `UXC_IDX_BASE0) begin
          scratch_low <= avs_writedata[7:0];
        end
        if (wr_go && idx == `UXC_IDX_BASE1) begin
          scratch_high <= avs_writedata[7:0];
        end
      end else if (legacy_port) begin
        // Any legacy port access falls back to compatible mode
        if (ext) begin
          modem_control_register <= modem_control_register & ~`UXC_MCR_FALLBACK_CLR;
        end
        extended_control_one <= extended_control_one & ~`UXC_X1_FALLBACK_CLR;
        fifo_and_prescaler_control <= fifo_and_prescaler_control & ~`UXC_X2_FALLBACK_CLR;
      end else if (wr_go) begin
        if (idx == `UXC_IDX_LCR_BSR) begin
          // Shared in every bank
          if (avs_writedata[`UXC_BSR_FLAG]) begin
            bank_select_register <= avs_writedata[2:0];
          end else begin
            line_control_register <= avs_writedata[7:0];
          end
        end else begin
          case (bank_select_register)
            `UXC_BANK0: begin
              if (idx == `UXC_IDX_BASE1) begin
                interrupt_enable_register <= avs_writedata[7:0];
              end
              if (idx == `UXC_IDX_BASE2) begin
                fifo_control_register <= avs_writedata[7:0];
              end
              if (idx == `UXC_IDX_BASE4) begin
                modem_control_register <= avs_writedata[7:0];
                // Loop bit shared with modem control bit 4
                if (!ext) begin
                  extended_control_one[`UXC_X1_LOOP] <= avs_writedata[`UXC_MCR_LOOP];
                end
              end
            end
            `UXC_BANK2: begin
              if (idx == `UXC_IDX_BASE2) begin
                extended_control_one <= avs_writedata[7:0] & `UXC_X1_WMASK;
              end
              if (idx == `UXC_IDX_BASE4) begin
                fifo_and_prescaler_control <= avs_writedata[7:0] & `UXC_X2_WMASK;
              end
              // Offsets 05h to 07h ignore writes
            end
            default: begin
              // Bank 3 and unmapped banks take no writes
            end
          endcase
        end
      end
    end
  end

  // Read data mux, latched at the edge before the answer
  always @* begin
    next_readdata = `UXC_RST_BYTE;
    if (idx == `UXC_IDX_LCR_BSR) begin
      next_readdata = line_control_register;
    end else begin
      case (bank_select_register)
        `UXC_BANK0: begin
          if (idx == `UXC_IDX_BASE1) begin
            next_readdata = interrupt_enable_register;
          end
          if (idx == `UXC_IDX_BASE4) begin
            next_readdata = {modem_control_register[7:5], loop, modem_control_register[3:0]};
          end
        end
        `UXC_BANK1: begin
          if (!ext && lock && idx == `UXC_IDX_BASE0) begin
            next_readdata = scratch_low;
          end
          if (!ext && lock && idx == `UXC_IDX_BASE1) begin
            next_readdata = scratch_high;
          end
        end
        `UXC_BANK2: begin
          case (idx)
            `UXC_IDX_BASE2: next_readdata = extended_control_one;
            `UXC_IDX_BASE4: next_readdata = fifo_and_prescaler_control;
            `UXC_IDX_TRANSMIT_FIFO_LEVEL: next_readdata = {2'h0, transmit_byte_count} & `UXC_LEVEL_MASK;
            `UXC_IDX_RECEIVE_FIFO_LEVEL: next_readdata = {2'h0, receive_byte_count} & `UXC_LEVEL_MASK;
            default: next_readdata = `UXC_RST_BYTE;
          endcase
        end
        `UXC_BANK3: begin
          case (idx)
            `UXC_IDX_BASE0: next_readdata = {`UXC_MODULE_TYPE, `UXC_REVISION};
            `UXC_IDX_BASE1: next_readdata = line_control_register;
            `UXC_IDX_BASE2: next_readdata = fifo_control_register;
            default: next_readdata = `UXC_RST_BYTE;
          endcase
        end
        default: next_readdata = `UXC_RST_BYTE;
      endcase
    end
  end

  // Read data register; reads have side effects only at the legacy divisor ports (fallback)
  always @(posedge sys_clk) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= {24'h00_0000, next_readdata};
    end
  end

  // Two-flop synchronisers for pins and the baud clock
  always @(posedge sys_clk) begin
    if (!rstn) begin
      ms_meta <= 4'hF;
      ms_sync <= 4'hF;
      rx_meta <= 2'h1;
      rx_sync <= 2'h1;
      baud_meta <= 1'b0;
      baud_sync <= 1'b0;
    end else if (clk_en) begin
      ms_meta <= {dcd_n_pin, ri_n_pin, cts_n_pin, dsr_n_pin};
      ms_sync <= ms_meta;
      rx_meta <= {ir_rxd_pin, uart_rxd_pin};
      rx_sync <= rx_meta;
      baud_meta <= baud_clk;
      baud_sync <= baud_meta;
    end
  end

  // Internal modem status, bits {dcd, ri, cts, dsr}, active high
  always @* begin
    next_status = ~ms_sync;
    if (loop) begin
      // Pins ignored; status from modem control bits
      if (ext) begin
        next_status = {modem_control_register[`UXC_MCR_RTS], modem_control_register[`UXC_MCR_DTR],
                       modem_control_register[`UXC_MCR_RTS], modem_control_register[`UXC_MCR_DTR]};
      end else begin
        next_status = {modem_control_register[`UXC_MCR_OUT2], modem_control_register[`UXC_MCR_OUT1],
                       modem_control_register[`UXC_MCR_RTS], modem_control_register[`UXC_MCR_DTR]};
      end
    end
  end

  // Modem status, change interrupt and serial routing
  always @(posedge sys_clk) begin
    if (!rstn) begin
      core_modem_status <= 4'h0;
      ms_prev <= 4'h0;
      ms_primed <= 1'b0;
      modem_status_irq <= 1'b0;
      core_rxd <= 1'b1;
      core_ir_rxd <= 1'b0;
      uart_txd_pin <= 1'b1;
      ir_txd_pin <= 1'b0;
      dtr_n_pin <= 1'b1;
      rts_n_pin <= 1'b1;
    end else if (clk_en) begin
      core_modem_status <= next_status;
      ms_prev <= next_status;
      ms_primed <= 1'b1;
      // Change event, gated by enable and infrared select
      modem_status_irq <= ms_primed && (next_status != ms_prev) &&
                          interrupt_enable_register[`UXC_IER_MS] &&
                          !(ir_mode_active && infrared_modem_status_select);
      // Receivers take transmitter outputs in loopback
      core_rxd <= loop ? core_txd : rx_sync[0];
      core_ir_rxd <= loop ? core_ir_txd : rx_sync[1];
      // Outputs parked unless transmit-during-loopback
      uart_txd_pin <= (loop && !extended_control_one[`UXC_X1_ETD]) ? 1'b1 : core_txd;
      ir_txd_pin <= (loop && !extended_control_one[`UXC_X1_ETD]) ? 1'b0 : core_ir_txd;
      // Baud clock test route on DTR
      dtr_n_pin <= extended_control_one[`UXC_X1_BAUD_CLOCK_TEST_ROUTE] ? baud_sync : ~modem_control_register[`UXC_MCR_DTR];
      rts_n_pin <= ~modem_control_register[`UXC_MCR_RTS];
    end
  end

  // DMA routing, unaffected by loopback
  always @(posedge sys_clk) begin
    if (!rstn) begin
      chan_a_drq <= 1'b0;
      chan_b_drq <= 1'b0;
      core_tx_dack <= 1'b0;
      core_rx_dack <= 1'b0;
    end else if (clk_en) begin
      if (extended_control_one[`UXC_X1_SWAP]) begin
        chan_a_drq <= core_rx_drq;
        chan_b_drq <= core_tx_drq;
        core_tx_dack <= chan_b_dack;
        core_rx_dack <= chan_a_dack;
      end else begin
        chan_a_drq <= core_tx_drq;
        chan_b_drq <= core_rx_drq;
        core_tx_dack <= chan_a_dack;
        core_rx_dack <= chan_b_dack;
      end
    end
  end

  // Configuration outputs to FIFOs and baud generator
  always @(posedge sys_clk) begin
    if (!rstn) begin
      prescaler_select <= 2'h0;
      transmit_fifo_32 <= 1'b0;
      receive_fifo_32 <= 1'b0;
      extended_mode <= 1'b0;
      loopback_active <= 1'b0;
    end else if (clk_en) begin
      prescaler_select <= fifo_and_prescaler_control[`UXC_X2_PRE_HI:`UXC_X2_PRE_LO];
      // Depth 32 only for code 01 with FIFOs enabled
      transmit_fifo_32 <= fifo_control_register[`UXC_FCR_EN] &&
                          (fifo_and_prescaler_control[`UXC_X2_TXSZ_HI:`UXC_X2_TXSZ_LO] == `UXC_FIFO_32);
      receive_fifo_32 <= fifo_control_register[`UXC_FCR_EN] &&
                         (fifo_and_prescaler_control[`UXC_X2_RXSZ_HI:`UXC_X2_RXSZ_LO] == `UXC_FIFO_32);
      extended_mode <= ext;
      loopback_active <= loop;
    end
  end

endmodule

// [testbench/uxc_far_end.sv]
// Far side model: remote serial line and modem pins
`timescale 1ns/1ps
module uxc_far_end (
  // Clock and mode
  input wire sys_clk,
  input wire hostile,
  // Serial and modem pins, modem active low
  output reg uart_rxd_pin,
  output reg ir_rxd_pin,
  output reg dsr_n_pin,
  output reg cts_n_pin,
  output reg ri_n_pin,
  output reg dcd_n_pin
);
  // Idle levels, or hostile mode toggling every line each cycle so ignored inputs show up
  always @(posedge sys_clk) begin
    if (hostile) begin
      {uart_rxd_pin, ir_rxd_pin} <= ~{uart_rxd_pin, ir_rxd_pin};
      {dsr_n_pin, cts_n_pin, ri_n_pin, dcd_n_pin} <= ~{dsr_n_pin, cts_n_pin, ri_n_pin, dcd_n_pin};
    end else begin
      {uart_rxd_pin, ir_rxd_pin} <= 2'h2;
      {dsr_n_pin, cts_n_pin, ri_n_pin, dcd_n_pin} <= 4'hF;
    end
  end
endmodule

// [testbench/uxc_ext_chk.sv]
// Port-level checker for the extended control block
`timescale 1ns/1ps
module uxc_ext_chk (
  // Clock and bus
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  // Serial and modem core side
  input wire core_txd,
  input wire core_ir_txd,
  input wire core_rxd,
  input wire core_ir_rxd,
  input wire [3:0] core_modem_status,
  input wire modem_status_irq,
  input wire loopback_active,
  input wire ir_mode_active,
  input wire infrared_modem_status_select,
  // DMA
  input wire core_tx_drq,
  input wire core_rx_drq,
  input wire core_tx_dack,
  input wire core_rx_dack,
  input wire chan_a_drq,
  input wire chan_b_drq,
  input wire chan_a_dack,
  input wire chan_b_dack
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Bus handshake steps
  sequence s_req;
    (avs_read || avs_write) && clk_en && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest;
  endsequence
  bus_one_wait_a: assert property (s_req |=> s_ans)
    else $error("bus answer late");
  rdata_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  // Swap is a permutation, so count and parity of requests are kept
  drq_route_a: assert property ($past(rstn) |->
    (chan_a_drq ^ chan_b_drq) == ($past(core_tx_drq) ^ $past(core_rx_drq))
    && (chan_a_drq & chan_b_drq) == ($past(core_tx_drq) & $past(core_rx_drq)))
    else $error("request routing wrong");
  dack_route_a: assert property ($past(rstn) |->
    (core_tx_dack ^ core_rx_dack) == ($past(chan_a_dack) ^ $past(chan_b_dack))
    && (core_tx_dack & core_rx_dack) == ($past(chan_a_dack) & $past(chan_b_dack)))
    else $error("acknowledge routing wrong");
  loop_rx_a: assert property (loopback_active [*3] |-> core_rxd == $past(core_txd))
    else $error("loopback serial path wrong");
  loop_ir_a: assert property (loopback_active [*3] |-> core_ir_rxd == $past(core_ir_txd))
    else $error("loopback infrared path wrong");
  modem_quiet_a: assert property ((loopback_active && !avs_write) [*4] |-> $stable(core_modem_status))
    else $error("modem status moved from pins");
  // Pulse and new status are launched by the same edge
  irq_cause_a: assert property ($past(rstn) && modem_status_irq
    |-> core_modem_status != $past(core_modem_status))
    else $error("irq without status change");
  ir_mute_a: assert property ((ir_mode_active && infrared_modem_status_select) [*2] |=> !modem_status_irq)
    else $error("irq in muted infrared mode");
endmodule
bind uxc_ext_ctrl uxc_ext_chk u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .core_txd(core_txd), .core_ir_txd(core_ir_txd),
  .core_rxd(core_rxd), .core_ir_rxd(core_ir_rxd), .core_modem_status(core_modem_status),
  .modem_status_irq(modem_status_irq), .loopback_active(loopback_active), .ir_mode_active(ir_mode_active),
  .infrared_modem_status_select(infrared_modem_status_select), .core_tx_drq(core_tx_drq),
  .core_rx_drq(core_rx_drq), .core_tx_dack(core_tx_dack), .core_rx_dack(core_rx_dack),
  .chan_a_drq(chan_a_drq), .chan_b_drq(chan_b_drq), .chan_a_dack(chan_a_dack), .chan_b_dack(chan_b_dack)
);

// [testbench/tb_uxc_ext_ctrl.sv]
// Self-checking bench for the extended control block
`timescale 1ns/1ps
`include "uxc_map.vh"
module tb_uxc_ext_ctrl;
  reg sys_clk, rstn, clk_en, avs_read, avs_write, core_txd, core_ir_txd, core_tx_drq, core_rx_drq;
  reg chan_a_dack, chan_b_dack, baud_clk, ir_mode_active, infrared_modem_status_select, hostile;
  reg [4:0] avs_address;
  reg [3:0] avs_byteenable;
  reg [31:0] avs_writedata;
  reg [5:0] transmit_byte_count, receive_byte_count;
  wire [31:0] avs_readdata;
  wire [3:0] core_modem_status;
  wire [1:0] prescaler_select;
  wire avs_waitrequest, core_rxd, core_ir_rxd, modem_status_irq, uart_txd_pin, ir_txd_pin, dtr_n_pin, rts_n_pin;
  wire core_tx_dack, core_rx_dack, chan_a_drq, chan_b_drq, transmit_fifo_32, receive_fifo_32;
  wire extended_mode, loopback_active, uart_rxd_pin, ir_rxd_pin, dsr_n_pin, cts_n_pin, ri_n_pin, dcd_n_pin;
  int n_errors, comparisons, cyc, n_irq, n0;
  reg [7:0] v;
  uxc_ext_ctrl u_uxc_ext_ctrl (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_txd(core_txd), .core_ir_txd(core_ir_txd),
    .core_rxd(core_rxd), .core_ir_rxd(core_ir_rxd), .core_modem_status(core_modem_status),
    .modem_status_irq(modem_status_irq), .uart_rxd_pin(uart_rxd_pin), .ir_rxd_pin(ir_rxd_pin),
    .uart_txd_pin(uart_txd_pin), .ir_txd_pin(ir_txd_pin), .dsr_n_pin(dsr_n_pin), .cts_n_pin(cts_n_pin),
    .ri_n_pin(ri_n_pin), .dcd_n_pin(dcd_n_pin), .dtr_n_pin(dtr_n_pin), .rts_n_pin(rts_n_pin),
    .core_tx_drq(core_tx_drq), .core_rx_drq(core_rx_drq), .core_tx_dack(core_tx_dack), .core_rx_dack(core_rx_dack),
    .chan_a_drq(chan_a_drq), .chan_b_drq(chan_b_drq), .chan_a_dack(chan_a_dack), .chan_b_dack(chan_b_dack),
    .baud_clk(baud_clk), .transmit_byte_count(transmit_byte_count), .receive_byte_count(receive_byte_count),
    .prescaler_select(prescaler_select), .transmit_fifo_32(transmit_fifo_32), .receive_fifo_32(receive_fifo_32),
    .extended_mode(extended_mode), .loopback_active(loopback_active), .ir_mode_active(ir_mode_active),
    .infrared_modem_status_select(infrared_modem_status_select)
  );
  uxc_far_end u_uxc_far_end (
    .sys_clk(sys_clk), .hostile(hostile), .uart_rxd_pin(uart_rxd_pin), .ir_rxd_pin(ir_rxd_pin),
    .dsr_n_pin(dsr_n_pin), .cts_n_pin(cts_n_pin), .ri_n_pin(ri_n_pin), .dcd_n_pin(dcd_n_pin)
  );
  // Clock
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Hang guard and irq pulse counter
  always @(posedge sys_clk) begin
    cyc++;
    if (modem_status_irq === 1'h1) n_irq++;
    if (cyc == 6000) begin
      n_errors++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input bit w, input [2:0] i, input [7:0] d, output [7:0] q);
    @(posedge sys_clk);
    avs_address <= {i, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic wr(input [2:0] i, input [7:0] d);
    bus(1, i, d, v);
  endtask
  task automatic rd(input [2:0] i, input [7:0] e);
    bus(0, i, 8'h0, v);
    chk(v, e);
  endtask
  task automatic sel(input [2:0] b);
    wr(3'h3, {5'h10, b});
  endtask
  // Triple read with vote, counts are not frozen
  task automatic lvl(input [2:0] i, input [7:0] e);
    reg [7:0] a, b, c;
    bus(0, i, 8'h0, a);
    bus(0, i, 8'h0, b);
    bus(0, i, 8'h0, c);
    chk((a == b) ? b : c, e);
  endtask
  task automatic t_reset;
    chk({uart_txd_pin, ir_txd_pin, dtr_n_pin, rts_n_pin, extended_mode, loopback_active}, 8'h2C);
  endtask
  task automatic t_shadow;
    sel(0);
    wr(3'h3, 8'h1B);
    wr(3'h2, 8'h41);
    sel(3);
    rd(3'h0, {`UXC_MODULE_TYPE, `UXC_REVISION});
    wr(3'h0, 8'h00);
    rd(3'h0, {`UXC_MODULE_TYPE, `UXC_REVISION});
    rd(3'h1, 8'h1B);
    rd(3'h1, 8'h1B);
    rd(3'h2, 8'h41);
    rd(3'h3, 8'h1B);
    wr(3'h4, 8'hFF);
    rd(3'h4, 8'h00);
  endtask
  task automatic t_ext;
    sel(2);
    wr(3'h2, 8'h01);
    idle(3);
    chk(extended_mode, 1);
    rd(3'h2, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(3'h4, {2'h0, i[1:0], 4'h4});
      idle(3);
      chk({prescaler_select, transmit_fifo_32, receive_fifo_32}, {i[1:0], 2'h1});
    end
    sel(0);
    wr(3'h2, 8'h00);
    sel(2);
    idle(3);
    chk(receive_fifo_32, 0);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    rd(3'h3, 8'h1B);
    transmit_byte_count <= 6'h2A;
    receive_byte_count <= 6'h3F;
    lvl(3'h6, 8'h2A);
    lvl(3'h7, 8'h3F);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h2A);
  endtask
  task automatic t_loop;
    hostile <= 1'h1;
    core_txd <= 1'h0;
    core_ir_txd <= 1'h1;
    wr(3'h2, 8'h11);
    idle(4);
    chk({loopback_active, core_rxd, core_ir_rxd}, 8'h5);
    chk({uart_txd_pin, ir_txd_pin}, 8'h2);
    wr(3'h2, 8'h31);
    idle(3);
    chk({uart_txd_pin, ir_txd_pin}, 8'h1);
    wr(3'h2, 8'h19);
    core_tx_drq <= 1'h1;
    chan_b_dack <= 1'h1;
    idle(3);
    chk({chan_a_drq, chan_b_drq, core_tx_dack, core_rx_dack}, 8'h6);
    wr(3'h2, 8'h11);
    idle(3);
    chk({chan_a_drq, chan_b_drq, core_tx_dack, core_rx_dack}, 8'h9);
    core_tx_drq <= 1'h0;
    chan_b_dack <= 1'h0;
    sel(0);
    wr(3'h1, 8'h08);
    n0 = n_irq;
    wr(3'h4, 8'h01);
    idle(4);
    chk(core_modem_status, 8'h5);
    chk(n_irq > n0, 1);
    wr(3'h4, 8'h02);
    idle(4);
    chk({rts_n_pin, core_modem_status}, 8'h0A);
    ir_mode_active <= 1'h1;
    infrared_modem_status_select <= 1'h1;
    n0 = n_irq;
    wr(3'h4, 8'h01);
    idle(4);
    chk(n_irq == n0, 1);
    infrared_modem_status_select <= 1'h0;
    wr(3'h4, 8'h02);
    idle(4);
    chk(n_irq > n0, 1);
    {hostile, ir_mode_active} <= 2'h0;
    wr(3'h4, 8'h00);
    sel(2);
    wr(3'h2, 8'h00);
    idle(5);
    chk(core_rxd, 1);
    core_txd <= 1'h1;
    // Legacy loopback through modem control bit 4, modem interrupt disabled
    sel(0);
    wr(3'h1, 8'h00);
    n0 = n_irq;
    wr(3'h4, 8'h1D);
    idle(4);
    chk({loopback_active, core_modem_status}, 8'h1D);
    chk(n_irq == n0, 1);
    sel(2);
    rd(3'h2, 8'h10);
    wr(3'h2, 8'h00);
    sel(0);
    wr(3'h4, 8'h00);
    sel(2);
  endtask
  task automatic t_lock;
    wr(3'h2, 8'h21);
    sel(1);
    rd(3'h0, 8'h00);
    idle(3);
    chk(extended_mode, 0);
    sel(2);
    wr(3'h4, 8'h80);
    sel(1);
    wr(3'h0, 8'h5A);
    wr(3'h1, 8'hC3);
    rd(3'h0, 8'h5A);
    rd(3'h1, 8'hC3);
    sel(2);
    rd(3'h4, 8'h80);
    wr(3'h4, 8'h00);
  endtask
  task automatic t_baud_clock_test_route;
    wr(3'h2, 8'h80);
    baud_clk <= 1'h0;
    idle(5);
    chk(dtr_n_pin, 0);
    baud_clk <= 1'h1;
    idle(5);
    chk(dtr_n_pin, 1);
    wr(3'h2, 8'h00);
  endtask
  // Main sequence
  initial begin
    {rstn, avs_read, avs_write, core_ir_txd, core_tx_drq, core_rx_drq, chan_a_dack, chan_b_dack} = 8'h0;
    {baud_clk, ir_mode_active, infrared_modem_status_select, hostile} = 4'h0;
    {clk_en, core_txd, avs_byteenable} = 6'h3F;
    {avs_address, avs_writedata, transmit_byte_count, receive_byte_count} = 49'h0;
    idle(8);
    t_reset;
    rstn <= 1'h1;
    t_shadow;
    t_ext;
    t_loop;
    t_lock;
    t_baud_clock_test_route;
    complete_run;
  end
endmodule
